// >>> logic/hs_io_pkg.sv
package hs_io_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned CLK_NS = 50;
	localparam int unsigned SETTLE_STEP_NS = 100;
	localparam int unsigned SETTLE_STEP_CYC = (SETTLE_STEP_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned SETTLE_MAX_CODE = 7;
	localparam int unsigned REPLY_SHORT_NS = 100;
	localparam int unsigned REPLY_SHORT_CYC = (REPLY_SHORT_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned REPLY_LONG_NS = 500;
	localparam int unsigned REPLY_LONG_CYC = (REPLY_LONG_NS + CLK_NS - 1) / CLK_NS;

	// ----------------------------------------
	// Register indices
	// ----------------------------------------
	localparam logic [2:0] ADDR_PORT_AB = 3'h0;
	localparam logic [2:0] ADDR_PORT_CD = 3'h1;
	localparam logic [2:0] ADDR_SETUP_G1 = 3'h2;
	localparam logic [2:0] ADDR_SETUP_G2 = 3'h3;
	localparam logic [2:0] ADDR_DIR = 3'h4;
	localparam logic [2:0] ADDR_EXTRA = 3'h5;
	localparam logic [2:0] ADDR_STATUS = 3'h6;

	// ----------------------------------------
	// Group setup fields
	// ----------------------------------------
	localparam int unsigned F_EN_LO = 0;
	localparam int unsigned F_EN_HI = 1;
	localparam int unsigned F_PULSE = 2;
	localparam int unsigned F_EDGE = 3;
	localparam int unsigned F_STB_FLIP = 4;
	localparam int unsigned F_RPL_FLIP = 5;
	localparam int unsigned F_MAN_RPL = 6;
	localparam int unsigned F_CLEAR = 7;
	localparam int unsigned F_SETTLE_LO = 8;
	localparam int unsigned F_SETTLE_HI = 10;
	localparam int unsigned F_SPARE_OUT = 11;
	localparam int unsigned F_CAPTURE = 12;

	// ----------------------------------------
	// Status fields, three bits per group
	// ----------------------------------------
	localparam int unsigned S_STB = 0;
	localparam int unsigned S_RPL = 1;
	localparam int unsigned S_RDY = 2;
	localparam int unsigned S_SPARE = 6;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [15:0] SETUP_RST = 16'h0000;
	localparam logic [3:0] DIR_RST = 4'h0;
	localparam logic [1:0] EXTRA_RST = 2'h0;
	localparam logic [7:0] PORT_RST = 8'h00;

	typedef enum {HS_IDLE, HS_SETTLE, HS_REPLY, HS_WAIT} hs_state_t;

endpackage

// >>> logic/hs_group_engine.sv
`timescale 1ns/1ps
module hs_group_engine #(
	parameter int unsigned CNT_W = 5
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic clear_in,
	input wire logic active_in,
	input wire logic write_mode_in,
	input wire logic launch_in,
	input wire logic pulse_in,
	input wire logic strobe_evt_in,
	input wire logic host_access_in,
	input wire logic [2:0] settle_sel_in,
	input wire logic long_in,
	output logic reply_active_out,
	output logic ready_out,
	output logic capture_out
);
	hs_io_pkg::hs_state_t state;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] settle_cyc;
	logic [CNT_W-1:0] width_cyc;
	logic armed;
	logic ready_set;
	logic ready_clr;
	logic idle_in;
	logic lvl_evt;

	// Counters must hold the longest delay and pulse
	if (hs_io_pkg::SETTLE_MAX_CODE * hs_io_pkg::SETTLE_STEP_CYC >= 2 ** CNT_W ||
		hs_io_pkg::REPLY_LONG_CYC >= 2 ** CNT_W) begin : bad_cnt_w
		$error("CNT_W too small for settle delay or reply pulse");
	end

	// Delay code steps uniformly, each step one settle unit
	assign settle_cyc = CNT_W'(32'(settle_sel_in) * hs_io_pkg::SETTLE_STEP_CYC);
	assign width_cyc = long_in ? CNT_W'(hs_io_pkg::REPLY_LONG_CYC - 1) : CNT_W'(hs_io_pkg::REPLY_SHORT_CYC - 1);
	assign idle_in = (state == hs_io_pkg::HS_IDLE) && !write_mode_in;
	assign lvl_evt = (state == hs_io_pkg::HS_REPLY) && !pulse_in && strobe_evt_in;
	// Input data is latched on the active strobe event
	assign capture_out = !write_mode_in && strobe_evt_in && (idle_in || lvl_evt);

	// ready set terms
	// Ready set and clear terms; set wins over a host access in the same cycle
	assign ready_set = (launch_in && write_mode_in) || capture_out ||
		(write_mode_in && lvl_evt) ||
		((state == hs_io_pkg::HS_WAIT) && strobe_evt_in);
	assign ready_clr = host_access_in && ready_out;

	// Sequencer: settle delay, reply pulse or level, wait for strobe
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state <= hs_io_pkg::HS_IDLE;
			cnt <= '0;
			reply_active_out <= 1'b0;
		end else if (clear_in || !active_in) begin
			state <= hs_io_pkg::HS_IDLE;
			cnt <= '0;
			reply_active_out <= 1'b0;
		end else begin
			case (state)
				hs_io_pkg::HS_IDLE: begin
					if ((write_mode_in && armed && ready_clr) || capture_out) begin
						cnt <= settle_cyc;
						state <= hs_io_pkg::HS_SETTLE;
					end
				end
				hs_io_pkg::HS_SETTLE: begin
					if (cnt == '0) begin
						reply_active_out <= 1'b1;
						cnt <= width_cyc;
						state <= hs_io_pkg::HS_REPLY;
					end else begin
						cnt <= cnt - 1'b1;
					end
				end
				hs_io_pkg::HS_REPLY: begin
					if (lvl_evt) begin
						reply_active_out <= 1'b0;
						cnt <= settle_cyc;
						state <= write_mode_in ? hs_io_pkg::HS_IDLE : hs_io_pkg::HS_SETTLE;
					end else if (pulse_in && cnt == '0) begin
						reply_active_out <= 1'b0;
						state <= write_mode_in ? hs_io_pkg::HS_WAIT : hs_io_pkg::HS_IDLE;
					end else if (pulse_in) begin
						cnt <= cnt - 1'b1;
					end
				end
				hs_io_pkg::HS_WAIT: begin
					if (strobe_evt_in) begin
						state <= hs_io_pkg::HS_IDLE;
					end
				end
				default: state <= hs_io_pkg::HS_IDLE;
			endcase
		end
	end

	// Armed only by a launch after reset or a group clear
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			armed <= 1'b0;
		end else if (clear_in || !active_in) begin
			armed <= 1'b0;
		end else if (launch_in) begin
			armed <= 1'b1;
		end
	end

	// Transfer ready flag
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ready_out <= 1'b0;
		end else if (clear_in || !active_in) begin
			ready_out <= 1'b0;
		end else if (ready_set) begin
			ready_out <= 1'b1;
		end else if (ready_clr) begin
			ready_out <= 1'b0;
		end
	end
endmodule

// >>> logic/strobed_parallel_handshake_io.sv
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
module strobed_parallel_handshake_io (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [2:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [15:0] rdata_out,
	input wire logic [31:0] port_lines_in,
	output logic [31:0] port_lines_out,
	output logic [3:0] port_oe_out,
	input wire logic peer_strobe_in_g1_in,
	input wire logic peer_strobe_in_g2_in,
	output logic handshake_reply_g1_out,
	output logic handshake_reply_g2_out,
	input wire logic spare_input_one_in,
	input wire logic spare_input_two_in,
	output logic spare_output_one_out,
	output logic spare_output_two_out
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [15:0] setup [2];
	logic [3:0] dir;
	logic [1:0] extra;
	logic [7:0] out_reg [4];
	logic [15:0] cap [2];
	logic [7:0] port_view [4];
	logic [1:0] stb_meta;
	logic [1:0] stb_sync;
	logic [1:0] stb_prev;
	logic [1:0] spare_meta;
	logic [1:0] spare_sync;
	logic [31:0] lines_meta;
	logic [31:0] lines_sync;
	logic [1:0] stb_now;
	logic [1:0] stb_evt;
	logic [1:0] grp_write;
	logic [1:0] grp_write_q;
	logic [1:0] grp_active;
	logic [1:0] reply_act;
	logic [1:0] ready;
	logic [1:0] capture;
	logic [1:0] reply_q;
	logic [15:0] next_rdata;
	logic [7:0] status;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			stb_meta <= 2'h0;
			stb_sync <= 2'h0;
		end else begin
			stb_meta <= {peer_strobe_in_g2_in, peer_strobe_in_g1_in};
			stb_sync <= stb_meta;
		end
	end

	// Spare inputs and port lines are asynchronous pins too
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			spare_meta <= 2'h0;
			spare_sync <= 2'h0;
			lines_meta <= 32'h0000_0000;
			lines_sync <= 32'h0000_0000;
		end else begin
			spare_meta <= {spare_input_two_in, spare_input_one_in};
			spare_sync <= spare_meta;
			lines_meta <= port_lines_in;
			lines_sync <= lines_meta;
		end
	end

	// Previous polarity-corrected strobe, for edge detection
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			stb_prev <= 2'h0;
			grp_write_q <= 2'h0;
		end else begin
			stb_prev <= stb_now;
			grp_write_q <= grp_write;
		end
	end

	// ----------------------------------------
	// Shared configuration registers
	// ----------------------------------------

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			dir <= hs_io_pkg::DIR_RST;
		end else if (wr_in && addr_in == hs_io_pkg::ADDR_DIR) begin
			dir <= wdata_in[3:0];
		end
	end

	// Long reply pulse select, one bit per group
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			extra <= hs_io_pkg::EXTRA_RST;
		end else if (wr_in && addr_in == hs_io_pkg::ADDR_EXTRA) begin
			extra <= wdata_in[1:0];
		end
	end

	// ----------------------------------------
	// Per-group logic
	// ----------------------------------------
	for (genvar g = 0; g < 2; g++) begin : grp
		localparam logic [2:0] PORT_ADDR = (g == 0) ? hs_io_pkg::ADDR_PORT_AB : hs_io_pkg::ADDR_PORT_CD;
		localparam logic [2:0] SETUP_ADDR = (g == 0) ? hs_io_pkg::ADDR_SETUP_G1 : hs_io_pkg::ADDR_SETUP_G2;
		logic [1:0] en;
		logic pulse;
		logic edge_sel;
		logic port_hit;
		logic host_access;
		logic next_reply;

		assign en = setup[g][hs_io_pkg::F_EN_HI:hs_io_pkg::F_EN_LO];
		assign pulse = setup[g][hs_io_pkg::F_PULSE];
		assign edge_sel = setup[g][hs_io_pkg::F_EDGE];
		assign grp_active[g] = |en;
		assign grp_write[g] = |(dir[2*g+1:2*g] & en);

		assign stb_now[g] = stb_sync[g] ^ setup[g][hs_io_pkg::F_STB_FLIP];
		// trailing edge when pulse and edge set
		// leading edge otherwise, level mode also reacts to the rise
		assign stb_evt[g] = (pulse && edge_sel) ? (stb_prev[g] && !stb_now[g]) : (!stb_prev[g] && stb_now[g]);

		// Host data access counts toward the handshake only in the group's direction
		assign port_hit = addr_in == PORT_ADDR;
		assign host_access = port_hit && (grp_write[g] ? wr_in : rd_in);

		// Group setup register
		always_ff @(posedge clk_in or posedge rst_in) begin
			if (rst_in) begin
				setup[g] <= hs_io_pkg::SETUP_RST;
			end else if (wr_in && addr_in == SETUP_ADDR) begin
				setup[g] <= wdata_in;
			end
		end

		// output latches written whatever the handshake state
		always_ff @(posedge clk_in or posedge rst_in) begin
			if (rst_in) begin
				out_reg[2*g] <= hs_io_pkg::PORT_RST;
				out_reg[2*g+1] <= hs_io_pkg::PORT_RST;
			end else if (wr_in && port_hit) begin
				out_reg[2*g] <= wdata_in[7:0];
				out_reg[2*g+1] <= wdata_in[15:8];
			end
		end

		// latch pin data on the strobe event
		always_ff @(posedge clk_in or posedge rst_in) begin
			if (rst_in) begin
				cap[g] <= 16'h0000;
			end else if (capture[g]) begin
				cap[g] <= lines_sync[16*g+15:16*g];
			end
		end

		// clear bit resets engine state, ready and reply; read-mode strobe events still capture
		hs_group_engine #(
			.CNT_W(5)
		) engine (
			.clk_in(clk_in),
			.rst_in(rst_in),
			.clear_in(setup[g][hs_io_pkg::F_CLEAR]),
			.active_in(grp_active[g]),
			.write_mode_in(grp_write[g]),
			.launch_in(grp_write[g] && !grp_write_q[g]),
			.pulse_in(pulse),
			.strobe_evt_in(stb_evt[g]),
			.host_access_in(host_access),
			.settle_sel_in(setup[g][hs_io_pkg::F_SETTLE_HI:hs_io_pkg::F_SETTLE_LO]),
			.long_in(extra[g]),
			.reply_active_out(reply_act[g]),
			.ready_out(ready[g]),
			.capture_out(capture[g])
		);

		assign next_reply = grp_active[g] ? (reply_act[g] ^ setup[g][hs_io_pkg::F_RPL_FLIP])
			: setup[g][hs_io_pkg::F_MAN_RPL];

		// Reply pin is registered so the output comes from a flop
		always_ff @(posedge clk_in or posedge rst_in) begin
			if (rst_in) begin
				reply_q[g] <= 1'b0;
			end else begin
				reply_q[g] <= next_reply;
			end
		end
	end

	// ----------------------------------------
	// Per-port read view
	// ----------------------------------------
	for (genvar p = 0; p < 4; p++) begin : port
		localparam int unsigned G = p / 2;
		logic buffered;

		// Capture applies only to an enabled input port of a receiving group
		assign buffered = setup[G][hs_io_pkg::F_EN_LO + (p % 2)] && setup[G][hs_io_pkg::F_CAPTURE] && !grp_write[G];

		// output port reads back its driven value
		always_comb begin
			if (dir[p]) begin
				port_view[p] = out_reg[p];
			end else if (buffered) begin
				port_view[p] = cap[G][8*(p%2)+7:8*(p%2)];
			end else begin
				port_view[p] = lines_sync[8*p+7:8*p];
			end
		end

		// Pins and enables come straight from the latches
		assign port_lines_out[8*p+7:8*p] = out_reg[p];
	end

	assign port_oe_out = dir;

	// ----------------------------------------
	// Status and read data
	// ----------------------------------------

	// pin levels as seen at the connector, with ready flags
	assign status = {spare_sync,
		ready[1], reply_q[1], stb_sync[1],
		ready[0], reply_q[0], stb_sync[0]};

	// Unmapped addresses read as zero
	always_comb begin
		case (addr_in)
			hs_io_pkg::ADDR_PORT_AB: next_rdata = {port_view[1], port_view[0]};
			hs_io_pkg::ADDR_PORT_CD: next_rdata = {port_view[3], port_view[2]};
			hs_io_pkg::ADDR_SETUP_G1: next_rdata = setup[0];
			hs_io_pkg::ADDR_SETUP_G2: next_rdata = setup[1];
			hs_io_pkg::ADDR_DIR: next_rdata = {12'h000, dir};
			hs_io_pkg::ADDR_EXTRA: next_rdata = {14'h0000, extra};
			hs_io_pkg::ADDR_STATUS: next_rdata = {8'h00, status};
			default: next_rdata = 16'h0000;
		endcase
	end

	// Read data stand only in the cycle after the strobe, zero otherwise
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_out <= 16'h0000;
		end else if (rd_in) begin
			rdata_out <= next_rdata;
		end else begin
			rdata_out <= 16'h0000;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign handshake_reply_g1_out = reply_q[0];
	assign handshake_reply_g2_out = reply_q[1];
	assign spare_output_one_out = setup[0][hs_io_pkg::F_SPARE_OUT];
	assign spare_output_two_out = setup[1][hs_io_pkg::F_SPARE_OUT];

endmodule

// >>> bench/hs_peer_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Peripheral on one handshake group
// ----------------------------------------
module hs_peer_model #(
	parameter int LAG = 4
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic reply_in,
	input wire logic go_in,
	input wire logic answer_in,
	input wire logic level_in,
	output logic strobe_out
);
	int lag;
	int pw;
	logic rp;
	// Strobe after a request or a fresh reply; long pulse so both edges can be told apart
	// strobe held or pulsed
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			strobe_out <= 1'b0;
			rp <= 1'b0;
			lag <= 0;
			pw <= 0;
		end else begin
			rp <= reply_in;
			if (lag == 1) begin
				strobe_out <= 1'b1;
				pw <= 6;
			end
			if (lag != 0) lag <= lag - 1;
			// Level mode answers a rising reply, pulse modes wait for the reply pulse to end
			else if (go_in || (answer_in && (level_in ? (reply_in && !rp) : (!reply_in && rp)))) lag <= LAG;
			if (pw != 0) pw <= pw - 1;
			if (strobe_out && lag == 0 && (level_in ? !reply_in : pw == 1)) strobe_out <= 1'b0;
		end
	end
endmodule

// >>> bench/strobed_parallel_handshake_io_props.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module hs_io_checker (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [2:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [15:0] rdata_out,
	input wire logic [31:0] port_lines_in,
	input wire logic [31:0] port_lines_out,
	input wire logic [3:0] port_oe_out,
	input wire logic peer_strobe_in_g1_in,
	input wire logic peer_strobe_in_g2_in,
	input wire logic handshake_reply_g1_out,
	input wire logic handshake_reply_g2_out,
	input wire logic spare_input_one_in,
	input wire logic spare_input_two_in,
	input wire logic spare_output_one_out,
	input wire logic spare_output_two_out
);
	logic [15:0] sh1;
	logic [15:0] sh2;
	logic [1:0] ex;
	logic armed;
	logic [4:0] cnt;
	logic a2;
	logic lvl1;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// Shadow setup words, so the checks know each group's mode
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sh1 <= 16'h0000;
			sh2 <= 16'h0000;
			ex <= 2'h0;
		end else if (wr_in) begin
			if (addr_in == hs_io_pkg::ADDR_SETUP_G1) sh1 <= wdata_in;
			if (addr_in == hs_io_pkg::ADDR_SETUP_G2) sh2 <= wdata_in;
			if (addr_in == hs_io_pkg::ADDR_EXTRA) ex <= wdata_in[1:0];
		end
	end
	// Cycles from a group 1 port write to its reply
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			armed <= 1'b0;
			cnt <= 5'h00;
		end else if (wr_in && addr_in == hs_io_pkg::ADDR_PORT_AB && port_oe_out[0] && sh1[1:0] != 2'h0) begin
			armed <= 1'b1;
			cnt <= 5'h00;
		end else begin
			armed <= armed && !handshake_reply_g1_out;
			cnt <= cnt + 5'h01;
		end
	end
	// Active reply level with the polarity flip removed
	assign a2 = handshake_reply_g2_out ^ sh2[5];
	assign lvl1 = sh1[1:0] != 2'h0 && sh1[5:2] == 4'h0 && !sh1[7];
	property p_spare;
		wr_in && addr_in == hs_io_pkg::ADDR_SETUP_G1 |=> spare_output_one_out == $past(wdata_in[11]);
	endproperty
	a_spare: assert property (p_spare) else $error("spare output off its setup bit");
	property p_dir;
		wr_in && addr_in == hs_io_pkg::ADDR_DIR |=> port_oe_out == $past(wdata_in[3:0]);
	endproperty
	a_dir: assert property (p_dir) else $error("drive enables off direction word");
	property p_latch;
		wr_in && addr_in == hs_io_pkg::ADDR_PORT_AB |=> port_lines_out[15:0] == $past(wdata_in);
	endproperty
	a_latch: assert property (p_latch) else $error("port word not latched");
	property p_readback;
		rd_in && addr_in == hs_io_pkg::ADDR_PORT_AB && port_oe_out[1:0] == 2'h3 |=> rdata_out == $past(port_lines_out[15:0]);
	endproperty
	a_readback: assert property (p_readback) else $error("output port read differs from driven");
	property p_manual;
		sh2[1:0] == 2'h0 && !sh2[5] && $stable(sh2) |-> handshake_reply_g2_out == sh2[6];
	endproperty
	a_manual: assert property (p_manual) else $error("idle reply not at manual level");
	property p_level_hold;
		(lvl1 && handshake_reply_g1_out && !peer_strobe_in_g1_in) [*4] |=> handshake_reply_g1_out;
	endproperty
	a_level_hold: assert property (p_level_hold) else $error("level reply dropped without strobe");
	property p_level_drop;
		lvl1 && handshake_reply_g1_out && $rose(peer_strobe_in_g1_in) |-> ##[2:6] !handshake_reply_g1_out;
	endproperty
	a_level_drop: assert property (p_level_drop) else $error("level reply kept after strobe");
	property p_pulse_short;
		sh1[2] && !ex[0] && !sh1[5] && $rose(handshake_reply_g1_out) |-> handshake_reply_g1_out [*2] ##1 !handshake_reply_g1_out;
	endproperty
	a_pulse_short: assert property (p_pulse_short) else $error("short reply pulse wrong width");
	property p_pulse_long;
		sh2[2] && ex[1] && $stable(sh2) && $rose(a2) |-> a2 [*8] ##1 a2 [*2] ##1 !a2;
	endproperty
	a_pulse_long: assert property (p_pulse_long) else $error("long reply pulse wrong width");
	property p_settle;
		$rose(handshake_reply_g1_out) && armed && !sh1[5] |-> cnt == {1'b0, sh1[10:8], 1'b0} + 5'h02;
	endproperty
	a_settle: assert property (p_settle) else $error("settle delay before reply wrong");
	c_level: cover property (lvl1 && $fell(handshake_reply_g1_out));
	c_long: cover property (ex[1] && $fell(a2));
	c_readback: cover property (rd_in && addr_in == hs_io_pkg::ADDR_PORT_AB && port_oe_out[0]);
endmodule

bind strobed_parallel_handshake_io hs_io_checker chk (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
	.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .port_lines_in(port_lines_in),
	.port_lines_out(port_lines_out), .port_oe_out(port_oe_out), .peer_strobe_in_g1_in(peer_strobe_in_g1_in),
	.peer_strobe_in_g2_in(peer_strobe_in_g2_in), .handshake_reply_g1_out(handshake_reply_g1_out),
	.handshake_reply_g2_out(handshake_reply_g2_out), .spare_input_one_in(spare_input_one_in),
	.spare_input_two_in(spare_input_two_in), .spare_output_one_out(spare_output_one_out),
	.spare_output_two_out(spare_output_two_out));

// >>> bench/strobed_parallel_handshake_io_tb_top.sv
`timescale 1ns/1ps
// ----------------------------------------
// Bench top
// ----------------------------------------
module strobed_parallel_handshake_io_tb_top;
	logic clk_in, rst_in, wr_in, rd_in, r1, r2, s1, s2, st1, st2, sp1, sp2, so1, so2;
	logic [2:0] addr_in;
	logic [15:0] wdata_in, rdata_out, s;
	logic [31:0] lines_in, lines_out, pin_data;
	logic [3:0] oe;
	logic go1, ans1, lvl1, ans2, lvl2, sflip1, rflip2;
	int error_cnt, n_compared;
	always #25 clk_in = ~clk_in;
	// Pins show the device's own drive where enabled, else the peripheral's data
	always_comb for (int i = 0; i < 4; i++) lines_in[i*8+:8] = oe[i] ? lines_out[i*8+:8] : pin_data[i*8+:8];
	assign s1 = st1 ^ sflip1;
	assign s2 = st2;
	strobed_parallel_handshake_io DUT (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .port_lines_in(lines_in), .port_lines_out(lines_out),
		.port_oe_out(oe), .peer_strobe_in_g1_in(s1), .peer_strobe_in_g2_in(s2), .handshake_reply_g1_out(r1),
		.handshake_reply_g2_out(r2), .spare_input_one_in(sp1), .spare_input_two_in(sp2),
		.spare_output_one_out(so1), .spare_output_two_out(so2));
	hs_peer_model P1 (.clk_in(clk_in), .rst_in(rst_in), .reply_in(r1), .go_in(go1), .answer_in(ans1),
		.level_in(lvl1), .strobe_out(st1));
	hs_peer_model P2 (.clk_in(clk_in), .rst_in(rst_in), .reply_in(r2 ^ rflip2), .go_in(1'b0), .answer_in(ans2),
		.level_in(lvl2), .strobe_out(st2));
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Bus cycles leave one idle edge so a strobe never changes twice in a step
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
		@(posedge clk_in);
	endtask
	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		// Take the data mid-cycle, while it stands, away from the edge that clears it
		@(negedge clk_in);
		d = rdata_out;
		@(posedge clk_in);
	endtask
	task automatic rdc(input logic [2:0] a, input logic [15:0] e, input string what);
		logic [15:0] d;
		rd(a, d);
		check(what, d, e);
	endtask
	task automatic wait_rdy(input int b);
		logic [15:0] d;
		for (int i = 0; i < 100; i++) begin
			rd(hs_io_pkg::ADDR_STATUS, d);
			if (d[b] === 1'b1) return;
		end
		check("ready flag", 16'h0000, 16'h0001);
	endtask
	task automatic t_reset;
		for (int a = 0; a < 8; a++) rdc(3'(a), 16'h0000, "reset value");
	endtask
	task automatic t_plain;
		wr(hs_io_pkg::ADDR_SETUP_G1, 16'h0800);
		wr(hs_io_pkg::ADDR_DIR, 16'h0003);
		wr(hs_io_pkg::ADDR_PORT_AB, 16'ha5c3);
		check("pins ab", lines_out[15:0], 16'ha5c3);
		check("spare out", {15'h0, so1}, 16'h0001);
		rdc(hs_io_pkg::ADDR_PORT_AB, 16'ha5c3, "port ab readback");
		pin_data[31:16] <= 16'h5a3c;
		sp2 <= 1'b1;
		repeat (4) @(posedge clk_in);
		rdc(hs_io_pkg::ADDR_PORT_CD, 16'h5a3c, "port cd live");
		rdc(hs_io_pkg::ADDR_STATUS, 16'h0080, "status spare");
		sp2 <= 1'b0;
		wr(hs_io_pkg::ADDR_DIR, 16'h0000);
		wr(hs_io_pkg::ADDR_SETUP_G1, 16'h0000);
	endtask
	task automatic t_manual;
		wr(hs_io_pkg::ADDR_SETUP_G2, 16'h0040);
		@(posedge clk_in);
		check("manual reply", {15'h0, r2}, 16'h0001);
		rdc(hs_io_pkg::ADDR_STATUS, 16'h0010, "status reply pin");
		wr(hs_io_pkg::ADDR_SETUP_G2, 16'h0000);
	endtask
	// Level-mode writes with a settle code of two, back to back
	task automatic t_level_write;
		lvl1 <= 1'b1;
		ans1 <= 1'b1;
		wr(hs_io_pkg::ADDR_SETUP_G1, 16'h0201);
		wr(hs_io_pkg::ADDR_DIR, 16'h0001);
		for (int i = 0; i < 2; i++) begin
			wait_rdy(2);
			wr(hs_io_pkg::ADDR_PORT_AB, i ? 16'h00c3 : 16'h003c);
			check("pins a", lines_out[15:0], i ? 16'h00c3 : 16'h003c);
		end
		wait_rdy(2);
		ans1 <= 1'b0;
		wr(hs_io_pkg::ADDR_DIR, 16'h0000);
		wr(hs_io_pkg::ADDR_SETUP_G1, 16'h0000);
	endtask
	// Leading-edge write on group 2 with long, inverted reply
	task automatic t_pulse_long;
		lvl2 <= 1'b0;
		wr(hs_io_pkg::ADDR_EXTRA, 16'h0002);
		wr(hs_io_pkg::ADDR_SETUP_G2, 16'h0125);
		rflip2 <= 1'b1;
		ans2 <= 1'b1;
		wr(hs_io_pkg::ADDR_DIR, 16'h0004);
		wait_rdy(5);
		wr(hs_io_pkg::ADDR_PORT_CD, 16'h00e7);
		check("pins c", lines_out[23:16], 16'h00e7);
		wait_rdy(5);
		check("idle reply high", {15'h0, r2}, 16'h0001);
		ans2 <= 1'b0;
		wr(hs_io_pkg::ADDR_DIR, 16'h0000);
		wr(hs_io_pkg::ADDR_SETUP_G2, 16'h0000);
		rflip2 <= 1'b0;
		wr(hs_io_pkg::ADDR_EXTRA, 16'h0000);
	endtask
	// Trailing-edge capture: data changes while strobe is high
	task automatic t_trail_read;
		sflip1 <= 1'b1;
		lvl1 <= 1'b0;
		pin_data[15:0] <= 16'h1111;
		// Flip first with the group off, so the pin swing makes no false event
		wr(hs_io_pkg::ADDR_SETUP_G1, 16'h1010);
		wr(hs_io_pkg::ADDR_SETUP_G1, 16'h101f);
		go1 <= 1'b1;
		@(posedge clk_in);
		go1 <= 1'b0;
		repeat (8) @(posedge clk_in);
		pin_data[15:0] <= 16'h3c96;
		wait_rdy(2);
		pin_data[15:0] <= 16'h0000;
		rd(hs_io_pkg::ADDR_STATUS, s);
		check("raw strobe pin", {15'h0, s[0]}, 16'h0001);
		rdc(hs_io_pkg::ADDR_PORT_AB, 16'h3c96, "captured word");
		wr(hs_io_pkg::ADDR_SETUP_G1, 16'h0000);
		sflip1 <= 1'b0;
	endtask
	task automatic t_clear;
		lvl1 <= 1'b1;
		wr(hs_io_pkg::ADDR_SETUP_G1, 16'h0001);
		wr(hs_io_pkg::ADDR_DIR, 16'h0001);
		wait_rdy(2);
		wr(hs_io_pkg::ADDR_SETUP_G1, 16'h0081);
		wr(hs_io_pkg::ADDR_SETUP_G1, 16'h0001);
		rd(hs_io_pkg::ADDR_STATUS, s);
		check("ready after clear", {15'h0, s[2]}, 16'h0000);
		wr(hs_io_pkg::ADDR_DIR, 16'h0000);
		wr(hs_io_pkg::ADDR_DIR, 16'h0001);
		wait_rdy(2);
		wr(hs_io_pkg::ADDR_DIR, 16'h0000);
		wr(hs_io_pkg::ADDR_SETUP_G1, 16'h0000);
	endtask
	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Watchdog well beyond the longest expected run
	initial begin
		#2000000;
		error_cnt++;
		conclude();
	end
	initial begin
		clk_in = 1'b0;
		rst_in = 1'b1;
		{addr_in, wdata_in, wr_in, rd_in, pin_data, sp1, sp2} = '0;
		{go1, ans1, lvl1, ans2, lvl2, sflip1, rflip2} = '0;
		error_cnt = 0;
		n_compared = 0;
		repeat (4) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		t_reset();
		t_plain();
		t_manual();
		t_level_write();
		t_pulse_long();
		t_trail_read();
		t_clear();
		conclude();
	end
endmodule
